// ===== verilog/node_params.svh
`ifndef NODE_PARAMS_SVH
`define NODE_PARAMS_SVH
`define CLK_MHZ 125
`define WDT_TIMEOUT_MS 1200
`define WDT_CYCLES (`WDT_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define BLINK_MS 500
`define BLINK_CYCLES (`BLINK_MS * 1000 * `CLK_MHZ)
`define NUM_CUR_CH 6
`define NUM_RELAY 8
`define ADDR_SETTLE 4
`define RSP_WAIT 16
`define ADDR_TENS_WEIGHT 10
`endif

// ===== verilog/node_pkg.sv
package node_pkg;
  typedef enum logic [3:0] {
    TYPE_NONE = 4'h0,
    TYPE_CURRENT = 4'h1,
    TYPE_RELAY = 4'h2
  } node_type_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } ctrl_state_t;
endpackage

// ===== verilog/node_link_if.sv
interface node_link_if;
  logic msg_valid;
  logic [6:0] msg_addr;
  node_pkg::node_type_t msg_type;
  logic [2:0] msg_chan;
  logic [11:0] msg_data;
  logic node_rst;
  logic rsp_valid;
  logic [6:0] rsp_addr;
  node_pkg::node_type_t rsp_type;
  logic [2:0] rsp_chan;
  logic [11:0] rsp_value;
  logic [7:0] rsp_status;
  modport ctrl (
    output msg_valid, msg_addr, msg_type, msg_chan, msg_data, node_rst,
    input rsp_valid, rsp_addr, rsp_type, rsp_chan, rsp_value, rsp_status
  );
  modport node (
    input msg_valid, msg_addr, msg_type, msg_chan, msg_data, node_rst,
    output rsp_valid, rsp_addr, rsp_type, rsp_chan, rsp_value, rsp_status
  );
endinterface

// ===== verilog/output_node.sv
`include "node_params.svh"
module output_node #(
  parameter bit RELAY_VARIANT = 1'b0,
  parameter int WDT_CYCLES = `WDT_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic SRST,
  node_link_if.node LINK,
  input wire logic [3:0] ADDR_TENS,
  input wire logic [3:0] ADDR_UNITS,
  input wire logic PROC_FAIL,
  input wire logic ADC_VALID,
  input wire logic [2:0] ADC_CHAN,
  input wire logic [11:0] ADC_DATA,
  input wire logic [7:0] RB_IN,
  output logic DAC_LOAD,
  output logic [2:0] DAC_CHAN,
  output logic [11:0] DAC_DATA,
  output logic CUR_DRV_EN,
  output logic RELAY_LOAD,
  output logic [7:0] RELAY_Q,
  output logic [7:0] RELAY_LED,
  output logic RELAY_DRV_EN,
  output logic FAULT_LED,
  output logic TRIPPED,
  output logic [6:0] NODE_ADDR
);
  localparam int WW = $clog2(WDT_CYCLES + 1) + 1;
  localparam int BW = $clog2(BLINK_CYCLES + 1) + 1;
  localparam node_pkg::node_type_t MY_TYPE =
    RELAY_VARIANT ? node_pkg::TYPE_RELAY : node_pkg::TYPE_CURRENT;

  // three-stage pin synchronisers, value taken when stages two and three agree
  logic [7:0] sw_s1_q, sw_s2_q, sw_s3_q, sw_q;
  logic [7:0] rb_s1_q, rb_s2_q, rb_s3_q, rb_q;
  logic [2:0] settle_q;
  logic captured_q;
  logic [6:0] addr_q;
  logic tripped_q;
  logic [WW-1:0] wdt_q;
  logic [11:0] adc_q [`NUM_CUR_CH];
  logic hit, good;
  logic [BW-1:0] blink_cnt_q;
  logic blink_q;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sw_s1_q <= 8'h00;
      sw_s2_q <= 8'h00;
      sw_s3_q <= 8'h00;
      sw_q <= 8'h00;
      rb_s1_q <= 8'h00;
      rb_s2_q <= 8'h00;
      rb_s3_q <= 8'h00;
      rb_q <= 8'h00;
    end else begin
      sw_s1_q <= {ADDR_TENS, ADDR_UNITS};
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q) begin
        sw_q <= sw_s3_q;
      end
      rb_s1_q <= RB_IN;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
      if (rb_s2_q == rb_s3_q) begin
        rb_q <= rb_s3_q;
      end
    end
  end

  // address taken once after reset release; later switch moves are ignored
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      settle_q <= 3'h0;
      captured_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (!captured_q) begin
      if (settle_q == 3'(`ADDR_SETTLE)) begin
        captured_q <= 1'b1;
        addr_q <= 7'(sw_q[7:4] * `ADDR_TENS_WEIGHT + sw_q[3:0]);
      end else begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // only frames carrying this node's address get any reaction
  assign hit = LINK.msg_valid && captured_q && (LINK.msg_addr == addr_q);
  assign good = hit && (LINK.msg_type == MY_TYPE) && !tripped_q;

  // watchdog: cleared by each converter or relay-register load
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wdt_q <= '0;
      tripped_q <= 1'b0;
    end else if (!tripped_q && captured_q) begin
      if (DAC_LOAD || RELAY_LOAD) begin
        wdt_q <= '0;
      end else if (wdt_q == WW'(WDT_CYCLES)) begin
        tripped_q <= 1'b1;
      end else begin
        wdt_q <= wdt_q + WW'(1);
      end
    end
  end

  // current variant: converter loads and driver enable
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DAC_LOAD <= 1'b0;
      DAC_CHAN <= 3'h0;
      DAC_DATA <= 12'h000;
      CUR_DRV_EN <= 1'b0;
    end else begin
      DAC_LOAD <= 1'b0;
      CUR_DRV_EN <= !RELAY_VARIANT && captured_q && !tripped_q;
      if (!RELAY_VARIANT && good && (LINK.msg_chan < 3'(`NUM_CUR_CH))) begin
        DAC_LOAD <= 1'b1;
        DAC_CHAN <= LINK.msg_chan;
        DAC_DATA <= LINK.msg_data;
      end
    end
  end

  // relay variant: register drives relays and their lamps
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RELAY_LOAD <= 1'b0;
      RELAY_Q <= 8'h00;
      RELAY_LED <= 8'h00;
      RELAY_DRV_EN <= 1'b0;
    end else begin
      RELAY_LOAD <= 1'b0;
      RELAY_DRV_EN <= RELAY_VARIANT && captured_q && !tripped_q;
      if (tripped_q) begin
        RELAY_Q <= 8'h00;
        RELAY_LED <= 8'h00;
      end else if (RELAY_VARIANT && good) begin
        RELAY_LOAD <= 1'b1;
        RELAY_Q <= LINK.msg_data[7:0];
        RELAY_LED <= LINK.msg_data[7:0];
      end
    end
  end

  // latest measured current per channel
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      for (int i = 0; i < `NUM_CUR_CH; i++) begin
        adc_q[i] <= 12'h000;
      end
    end else if (ADC_VALID && (ADC_CHAN < 3'(`NUM_CUR_CH))) begin
      adc_q[ADC_CHAN] <= ADC_DATA;
    end
  end

  // reply one cycle after an addressed frame; a node reset drops it
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_addr <= 7'h00;
      LINK.rsp_type <= node_pkg::TYPE_NONE;
      LINK.rsp_chan <= 3'h0;
      LINK.rsp_value <= 12'h000;
      LINK.rsp_status <= 8'h00;
    end else begin
      LINK.rsp_valid <= hit && !LINK.node_rst;
      if (hit) begin
        LINK.rsp_addr <= addr_q;
        LINK.rsp_type <= MY_TYPE;
        LINK.rsp_chan <= LINK.msg_chan;
        if (RELAY_VARIANT) begin
          LINK.rsp_value <= {4'h0, rb_q};
          LINK.rsp_status <= rb_q ^ RELAY_Q;
        end else begin
          if (LINK.msg_chan < 3'(`NUM_CUR_CH)) begin
            LINK.rsp_value <= adc_q[LINK.msg_chan];
          end else begin
            LINK.rsp_value <= 12'h000;
          end
          LINK.rsp_status <= {6'h00, tripped_q, CUR_DRV_EN};
        end
      end
    end
  end

  // fault lamp: steady for processor failure, blinking after a trip
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      FAULT_LED <= 1'b0;
      TRIPPED <= 1'b0;
      NODE_ADDR <= 7'h00;
    end else begin
      if (blink_cnt_q == BW'(BLINK_CYCLES - 1)) begin
        blink_cnt_q <= '0;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + BW'(1);
      end
      FAULT_LED <= PROC_FAIL || (tripped_q && blink_q);
      TRIPPED <= tripped_q;
      NODE_ADDR <= addr_q;
    end
  end
endmodule

// ===== verilog/net_controller.sv
`include "node_params.svh"
module net_controller #(
  parameter int RSP_WAIT = `RSP_WAIT
) (
  input wire logic CLOCK,
  input wire logic SRST,
  node_link_if.ctrl LINK,
  input wire logic CMD_VALID,
  input wire logic [6:0] CMD_ADDR,
  input wire node_pkg::node_type_t CMD_TYPE,
  input wire logic [2:0] CMD_CHAN,
  input wire logic [11:0] CMD_DATA,
  input wire logic NODE_RESET_REQ,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [2:0] RSP_CHAN,
  output logic [11:0] RSP_VALUE,
  output logic [7:0] RSP_STATUS,
  output logic FAULT_NOMSG,
  output logic FAULT_ADDR,
  output logic FAULT_TYPE
);
  localparam int CW = $clog2(RSP_WAIT + 1);
  node_pkg::ctrl_state_t state_q;
  logic [CW-1:0] wait_q;
  logic [1:0] seen_q;
  logic type_bad_q;
  node_pkg::node_type_t exp_type_q;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= node_pkg::ST_IDLE;
      wait_q <= '0;
      seen_q <= 2'h0;
      type_bad_q <= 1'b0;
      exp_type_q <= node_pkg::TYPE_NONE;
      CMD_READY <= 1'b0;
      LINK.msg_valid <= 1'b0;
      LINK.msg_addr <= 7'h00;
      LINK.msg_type <= node_pkg::TYPE_NONE;
      LINK.msg_chan <= 3'h0;
      LINK.msg_data <= 12'h000;
    end else begin
      LINK.msg_valid <= 1'b0;
      CMD_READY <= 1'b0;
      unique case (state_q)
        node_pkg::ST_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            LINK.msg_valid <= 1'b1;
            LINK.msg_addr <= CMD_ADDR;
            LINK.msg_type <= CMD_TYPE;
            LINK.msg_chan <= CMD_CHAN;
            LINK.msg_data <= CMD_DATA;
            exp_type_q <= CMD_TYPE;
            state_q <= node_pkg::ST_SEND;
          end
        end
        node_pkg::ST_SEND: begin
          wait_q <= '0;
          seen_q <= 2'h0;
          type_bad_q <= 1'b0;
          state_q <= node_pkg::ST_WAIT;
        end
        node_pkg::ST_WAIT: begin
          if (LINK.rsp_valid && LINK.rsp_addr == LINK.msg_addr) begin
            if (seen_q != 2'h3) begin
              seen_q <= seen_q + 2'h1;
            end
            if (LINK.rsp_type != exp_type_q) begin
              type_bad_q <= 1'b1;
            end
          end
          if (wait_q == CW'(RSP_WAIT)) begin
            state_q <= node_pkg::ST_DONE;
          end else begin
            wait_q <= wait_q + CW'(1);
          end
        end
        node_pkg::ST_DONE: begin
          state_q <= node_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // fault flags recomputed on every poll, so they clear once the cause goes
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      FAULT_NOMSG <= 1'b0;
      FAULT_ADDR <= 1'b0;
      FAULT_TYPE <= 1'b0;
      LINK.node_rst <= 1'b0;
    end else begin
      LINK.node_rst <= NODE_RESET_REQ;
      if (state_q == node_pkg::ST_DONE) begin
        FAULT_NOMSG <= (seen_q == 2'h0);
        FAULT_ADDR <= (seen_q >= 2'h2);
        FAULT_TYPE <= type_bad_q && (seen_q != 2'h0);
      end else if (NODE_RESET_REQ) begin
        FAULT_NOMSG <= 1'b0;
      end
    end
  end

  // first answer of the poll goes to the user side
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RSP_VALID <= 1'b0;
      RSP_CHAN <= 3'h0;
      RSP_VALUE <= 12'h000;
      RSP_STATUS <= 8'h00;
    end else begin
      RSP_VALID <= 1'b0;
      if (state_q == node_pkg::ST_WAIT && LINK.rsp_valid && seen_q == 2'h0
          && LINK.rsp_addr == LINK.msg_addr) begin
        RSP_VALID <= 1'b1;
        RSP_CHAN <= LINK.rsp_chan;
        RSP_VALUE <= LINK.rsp_value;
        RSP_STATUS <= LINK.rsp_status;
      end
    end
  end
endmodule

// ===== bench/node_link_chk.sv
module node_link_chk (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic msg_valid,
  input wire logic [6:0] msg_addr,
  input wire logic [2:0] msg_chan,
  input wire logic node_rst,
  input wire logic rsp_valid,
  input wire logic [6:0] rsp_addr,
  input wire node_pkg::node_type_t rsp_type,
  input wire logic [2:0] rsp_chan,
  input wire logic [11:0] rsp_value,
  input wire logic [7:0] rsp_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic trip_seen_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // remembers a trip reported over the link until reset
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      trip_seen_q <= 1'b0;
    end else if (rsp_valid && rsp_status[1]) begin
      trip_seen_q <= 1'b1;
    end
  end
  rsp_after_msg_a: assert property (rsp_valid |-> $past(msg_valid) && !$past(node_rst))
    else $error("answer without a preceding frame");
  rsp_addr_echo_a: assert property (rsp_valid |-> rsp_addr == $past(msg_addr))
    else $error("answer from a foreign address");
  rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  rst_mutes_rsp_a: assert property (node_rst |=> !rsp_valid)
    else $error("answer during node reset");
  rsp_type_a: assert property (rsp_valid |-> rsp_type == node_pkg::TYPE_CURRENT)
    else $error("wrong node type reported");
  rsp_chan_echo_a: assert property (rsp_valid |-> rsp_chan == $past(msg_chan))
    else $error("answer channel differs");
  status_upper_a: assert property (rsp_valid |-> rsp_status[7:2] == 6'h00)
    else $error("unused status bits set");
  trip_sticky_a: assert property (rsp_valid && trip_seen_q |-> rsp_status[1:0] == 2'b10)
    else $error("node revived after trip");
  answer_c: cover property (rsp_valid);
  node_rst_c: cover property (node_rst);
  trip_c: cover property (rsp_valid && rsp_status[1]);
  rst_frame_c: cover property (node_rst && msg_valid);
endmodule

// ===== bench/output_node_comm_watchdog_tb.sv
module output_node_comm_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDT = 200;
  logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, rst_req = 1'b0, proc_fail = 1'b0;
  logic adc_valid = 1'b0;
  logic [2:0] adc_chan = 3'h0, cmd_chan = 3'h0, dac_chan, rsp_chan, last_chan;
  logic [11:0] adc_data = 12'h000, cmd_data = 12'h000, dac_data, rsp_value, last_data;
  logic [6:0] cmd_addr = 7'h00, node_addr;
  logic [3:0] tens = 4'h4, units = 4'h2;
  node_pkg::node_type_t cmd_type = node_pkg::TYPE_CURRENT;
  logic cmd_ready, rsp_valid, f_nomsg, f_addr, f_type, dac_load, cur_en, fault_led, tripped;
  logic cmd_valid_r = 1'b0, cmd_ready_r, rsp_valid_r, f_type_r, tripped_r, relay_en;
  logic got_rsp, led_was;
  logic [2:0] got_chan;
  logic [7:0] rsp_status, got_status, rsp_status_r, relay_q, relay_led, rb_in = 8'hA4;
  logic [11:0] got_value, rsp_value_r;
  int bad_count = 0, num_checks = 0, dac_cnt = 0, n;
  node_link_if link ();
  node_link_if link_r ();
  always #4 clk = ~clk;
  net_controller u_net_controller (.CLOCK(clk), .SRST(srst), .LINK(link.ctrl),
    .CMD_VALID(cmd_valid), .CMD_ADDR(cmd_addr), .CMD_TYPE(cmd_type), .CMD_CHAN(cmd_chan),
    .CMD_DATA(cmd_data), .NODE_RESET_REQ(rst_req), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_CHAN(rsp_chan), .RSP_VALUE(rsp_value),
    .RSP_STATUS(rsp_status), .FAULT_NOMSG(f_nomsg), .FAULT_ADDR(f_addr),
    .FAULT_TYPE(f_type));
  output_node #(.RELAY_VARIANT(1'b0), .WDT_CYCLES(WDT), .BLINK_CYCLES(8)) u_output_node (
    .CLOCK(clk), .SRST(srst), .LINK(link.node), .ADDR_TENS(tens), .ADDR_UNITS(units),
    .PROC_FAIL(proc_fail), .ADC_VALID(adc_valid), .ADC_CHAN(adc_chan), .ADC_DATA(adc_data),
    .RB_IN(8'h00), .DAC_LOAD(dac_load), .DAC_CHAN(dac_chan), .DAC_DATA(dac_data),
    .CUR_DRV_EN(cur_en), .RELAY_LOAD(), .RELAY_Q(), .RELAY_LED(), .RELAY_DRV_EN(),
    .FAULT_LED(fault_led), .TRIPPED(tripped), .NODE_ADDR(node_addr));
  // relay variant on a link of its own
  net_controller u_net_controller_r (.CLOCK(clk), .SRST(srst), .LINK(link_r.ctrl),
    .CMD_VALID(cmd_valid_r), .CMD_ADDR(cmd_addr), .CMD_TYPE(cmd_type), .CMD_CHAN(cmd_chan),
    .CMD_DATA(cmd_data), .NODE_RESET_REQ(1'b0), .CMD_READY(cmd_ready_r),
    .RSP_VALID(rsp_valid_r), .RSP_CHAN(), .RSP_VALUE(rsp_value_r),
    .RSP_STATUS(rsp_status_r), .FAULT_NOMSG(), .FAULT_ADDR(), .FAULT_TYPE(f_type_r));
  output_node #(.RELAY_VARIANT(1'b1), .WDT_CYCLES(WDT), .BLINK_CYCLES(8)) u_output_node_r (
    .CLOCK(clk), .SRST(srst), .LINK(link_r.node), .ADDR_TENS(tens), .ADDR_UNITS(units),
    .PROC_FAIL(1'b0), .ADC_VALID(1'b0), .ADC_CHAN(3'h0), .ADC_DATA(12'h000),
    .RB_IN(rb_in), .DAC_LOAD(), .DAC_CHAN(), .DAC_DATA(), .CUR_DRV_EN(),
    .RELAY_LOAD(), .RELAY_Q(relay_q), .RELAY_LED(relay_led), .RELAY_DRV_EN(relay_en),
    .FAULT_LED(), .TRIPPED(tripped_r), .NODE_ADDR());
  node_link_chk u_node_link_chk (.CLOCK(clk), .SRST(srst), .msg_valid(link.msg_valid),
    .msg_addr(link.msg_addr), .msg_chan(link.msg_chan), .node_rst(link.node_rst),
    .rsp_valid(link.rsp_valid), .rsp_addr(link.rsp_addr), .rsp_type(link.rsp_type),
    .rsp_chan(link.rsp_chan), .rsp_value(link.rsp_value), .rsp_status(link.rsp_status));
  always @(posedge clk) begin
    if (dac_load === 1'b1) begin
      dac_cnt++;
      last_chan <= dac_chan;
      last_data <= dac_data;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // one poll from take until the controller is ready again
  task automatic poll(input bit r, input logic [6:0] a, input node_pkg::node_type_t t,
                      input logic [2:0] c, input logic [11:0] d);
    got_rsp = 1'b0;
    {got_chan, got_value, got_status} = 'x;
    @(posedge clk);
    cmd_valid <= !r;
    cmd_valid_r <= r;
    cmd_addr <= a;
    cmd_type <= t;
    cmd_chan <= c;
    cmd_data <= d;
    // request stands until ready is seen high at an edge
    do @(posedge clk); while ((r ? cmd_ready_r : cmd_ready) !== 1'b1);
    cmd_valid <= 1'b0;
    cmd_valid_r <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if ((r ? rsp_valid_r : rsp_valid) === 1'b1) begin
        got_rsp = 1'b1;
        got_chan = rsp_chan;
        got_value = r ? rsp_value_r : rsp_value;
        got_status = r ? rsp_status_r : rsp_status;
      end
      if ((r ? cmd_ready_r : cmd_ready) === 1'b1) break;
    end
    if (n == 40) bad_count++;
  endtask
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    idle(20);
  endtask
  initial begin
    idle(2);
    srst <= 1'b0;
    idle(20);
    check(node_addr, 7'h2A);
    poll(1'b1, 7'h2A, node_pkg::TYPE_RELAY, 3'h0, 12'h0A5);
    poll(1'b1, 7'h2A, node_pkg::TYPE_RELAY, 3'h0, 12'h0A5);
    check({relay_q, relay_led, relay_en}, {16'hA5A5, 1'b1});
    check({got_value, got_status}, {12'h0A4, 8'h01});
    poll(1'b1, 7'h2A, node_pkg::TYPE_CURRENT, 3'h0, 12'h0FF);
    check({f_type_r, relay_q}, {1'b1, 8'hA5});
    for (int i = 0; i < 6; i++) begin
      poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, i[2:0], 12'h111 * i[11:0]);
      check({last_chan, last_data}, {i[2:0], 12'h111 * i[11:0]});
    end
    check(dac_cnt, 6);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_chan <= 3'h2;
    adc_data <= 12'hABC;
    @(posedge clk);
    adc_valid <= 1'b0;
    poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h2, 12'h7FF);
    check({got_chan, got_value, got_status}, {3'h2, 12'hABC, 8'h01});
    check(cur_en, 1'b1);
    poll(1'b0, 7'h10, node_pkg::TYPE_CURRENT, 3'h0, 12'h000);
    check(f_nomsg, 1'b1);
    poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h0, 12'h001);
    check({f_nomsg, f_addr}, 2'b00);
    poll(1'b0, 7'h2A, node_pkg::TYPE_RELAY, 3'h1, 12'hFFF);
    check({f_type, dac_cnt[7:0]}, {1'b1, 8'h08});
    poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h1, 12'h002);
    check(f_type, 1'b0);
    poll(1'b0, 7'h11, node_pkg::TYPE_CURRENT, 3'h0, 12'h000);
    rst_req <= 1'b1;
    poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h0, 12'h003);
    rst_req <= 1'b0;
    idle(3);
    check({got_rsp, f_nomsg}, 2'b00);
    check(fault_led, 1'b0);
    @(posedge clk);
    proc_fail <= 1'b1;
    tens <= 4'h5;
    units <= 4'h5;
    idle(6);
    check({fault_led, node_addr}, {1'b1, 7'h2A});
    proc_fail <= 1'b0;
    // loads spaced just inside the timeout keep the node alive
    repeat (3) begin
      poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h3, 12'h333);
      idle(170);
    end
    check(tripped, 1'b0);
    idle(WDT + 20);
    check({tripped, cur_en}, 2'b10);
    check({tripped_r, relay_en, relay_q, relay_led}, {2'b10, 16'h0000});
    led_was = fault_led;
    idle(8);
    check(fault_led, !led_was);
    poll(1'b0, 7'h2A, node_pkg::TYPE_CURRENT, 3'h4, 12'h444);
    check({tripped, cur_en, got_status}, {2'b10, 8'h02});
    check(dac_cnt, 13);
    do_reset();
    check({tripped, node_addr}, {1'b0, 7'h37});
    poll(1'b0, 7'h37, node_pkg::TYPE_CURRENT, 3'h5, 12'h555);
    check({cur_en, got_status, last_data}, {1'b1, 8'h01, 12'h555});
    print_verdict();
  end
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
